// [pkg/wakeup_pkg.sv]
// constants shared by the wakeup flag and pin filter block
package wakeup_pkg;

  // apb word geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices, byte address is four times the index
  localparam int IDX_MODFLAGS = 4;
  localparam int IDX_FILT1    = 5;
  localparam int IDX_IRQ_STAT = 8;
  localparam int IDX_IRQ_CLR  = 9;
  localparam int IDX_IRQ_EN   = 10;
  localparam logic [ADDR_W-1:0] ADDR_MODFLAGS = ADDR_W'(IDX_MODFLAGS * 4);
  localparam logic [ADDR_W-1:0] ADDR_FILT1    = ADDR_W'(IDX_FILT1 * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = ADDR_W'(IDX_IRQ_STAT * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = ADDR_W'(IDX_IRQ_CLR * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = ADDR_W'(IDX_IRQ_EN * 4);

  // filter register fields
  localparam int FLAG_BIT = 7;
  localparam int EDGE_HI  = 6;
  localparam int EDGE_LO  = 5;
  localparam int RSVD_BIT = 4;
  localparam int SEL_HI   = 3;
  localparam int SEL_W    = 4;
  localparam int PINS     = 16;
  localparam int MODS     = 8;

  // interrupt status bits
  localparam int IRQ_W        = 2;
  localparam int IRQ_FILT_BIT = 0;
  localparam int IRQ_MOD_BIT  = 1;

  // reset values
  localparam logic [1:0]       EDGE_RST   = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RST    = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;

  // edge detect modes of the filter
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_mode_type;

  // timing: low power oscillator taken as 1 kHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int LPO_PERIOD_NS = 1000000;
  localparam int LPO_DIV_CYC   = LPO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FILT_CYC      = 3;
  localparam int SYNC_CYC      = 2;
  localparam int INIT_WAIT_LPO = 5;

endpackage

// [src/pin_glitch_filter.sv]
// lpo-paced pin synchroniser, glitch filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module pin_glitch_filter
  import wakeup_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      lpo_tick,
  input  wire logic                      pin_in,
  input  wire wakeup_pkg::edge_mode_type edge_mode,
  output logic                           detect
);
  logic       sync_a_r, sync_a_nxt;
  logic       sync_b_r, sync_b_nxt;
  logic       level_r, level_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       det_r, det_nxt;
  logic       match;

  ////////////////////////////////////////////////////////////////////////////
  // edge qualifier, off mode never matches
  always_comb begin
    case (edge_mode)
      EDGE_RISE: match = sync_b_r;
      EDGE_FALL: match = !sync_b_r;
      EDGE_ANY:  match = 1'b1;
      default:   match = 1'b0;
    endcase
  end

  // two sync stages then a three-tick stability count
  always_comb begin
    sync_a_nxt = sync_a_r;
    sync_b_nxt = sync_b_r;
    level_nxt  = level_r;
    cnt_nxt    = cnt_r;
    det_nxt    = 1'b0;
    if (lpo_tick) begin
      sync_a_nxt = pin_in;
      sync_b_nxt = sync_a_r;
      if (sync_b_r == level_r) begin
        cnt_nxt = 2'h0; // glitch shorter than the window dies here
      end else if (cnt_r == 2'(FILT_CYC - 1)) begin
        level_nxt = sync_b_r;
        cnt_nxt   = 2'h0;
        det_nxt   = match;
      end else begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
      level_r  <= 1'b0;
      cnt_r    <= 2'h0;
      det_r    <= 1'b0;
    end else begin
      sync_a_r <= sync_a_nxt;
      sync_b_r <= sync_b_nxt;
      level_r  <= level_nxt;
      cnt_r    <= cnt_nxt;
      det_r    <= det_nxt;
    end
  end

  assign detect = det_r;

  ////////////////////////////////////////////////////////////////////////////
  // a level change shorter than the window never reaches the output
  glitch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    lpo_tick && sync_b_r != level_r && cnt_r != 2'(FILT_CYC - 1)
    |=> level_r == $past(level_r) && !det_r)
    else $error("filtered level moved before the window ran out");
  off_nodet_a: assert property (@(posedge pclk) disable iff (!presetn)
    edge_mode == EDGE_OFF |=> !det_r)
    else $error("detect while filter is off");
endmodule
`default_nettype wire

// [src/wakeup_flags_pin_filter.sv]
// apb register block: module wakeup flags and pin filter one
`timescale 1ns/1ps
`default_nettype none
module wakeup_flags_pin_filter
  import wakeup_pkg::*;
#(
  parameter int LPO_DIV = wakeup_pkg::LPO_DIV_CYC
)(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [wakeup_pkg::ADDR_W-1:0] paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [wakeup_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [wakeup_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [wakeup_pkg::MODS-1:0]   module_flag_in,
  input  wire logic [wakeup_pkg::PINS-1:0]   wake_pins,
  input  wire logic                          lls_active,
  input  wire logic                          other_reset,
  output logic                               irq
);
  localparam int DIV_W = $clog2(LPO_DIV);

  logic [DIV_W-1:0]   div_r, div_nxt;
  logic               tick_r, tick_nxt;
  logic [MODS-1:0]    mod_r, mod_nxt;
  logic               flag_r, flag_nxt;
  edge_mode_type      mode_r, mode_nxt;
  logic [SEL_W-1:0]   sel_r, sel_nxt;
  logic [IRQ_W-1:0]   stat_r, stat_nxt;
  logic [IRQ_W-1:0]   en_r, en_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic               err_r, err_nxt;
  logic               setup, wr_acc, wr_b0, mapped;
  logic               detect, pin_sel, flag_set, mod_rise;
  logic [IRQ_W-1:0]   events;

  ////////////////////////////////////////////////////////////////////////////
  // lpo rate enable, one pulse per oscillator period
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + DIV_W'(1);
    if (div_r == DIV_W'(LPO_DIV - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin routing and the filter itself
  assign pin_sel = wake_pins[sel_r];

  pin_glitch_filter u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .lpo_tick  (tick_r),
    .pin_in    (pin_sel),
    .edge_mode (mode_r),
    .detect    (detect)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, answer prepared in the setup cycle
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !err_r;
  assign wr_b0  = wr_acc && pstrb[0];
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      ADDR_MODFLAGS, ADDR_FILT1, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read mux; the clear register reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      rdata_nxt = '0;
      err_nxt   = !mapped;
      if (!pwrite) begin
        case (paddr)
          ADDR_MODFLAGS: rdata_nxt[MODS-1:0] = mod_r;
          ADDR_FILT1: begin
            rdata_nxt[FLAG_BIT]         = flag_r;
            rdata_nxt[EDGE_HI:EDGE_LO]  = mode_r;
            rdata_nxt[RSVD_BIT]         = 1'b0;
            rdata_nxt[SEL_HI:0]         = sel_r;
          end
          ADDR_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
          ADDR_IRQ_EN:   rdata_nxt[IRQ_W-1:0] = en_r;
          default:       rdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign prdata  = rdata_r;
  assign pslverr = err_r && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // module flags: plain mirror, bus writes cannot touch them
  always_comb begin
    mod_nxt = module_flag_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter register; only the chip reset clears it, other_reset does not
  assign flag_set = detect && lls_active;
  always_comb begin
    flag_nxt = flag_r;
    mode_nxt = mode_r;
    sel_nxt  = sel_r;
    if (wr_b0 && paddr == ADDR_FILT1) begin
      if (pwdata[FLAG_BIT]) begin
        flag_nxt = 1'b0;
      end
      mode_nxt = edge_mode_type'(pwdata[EDGE_HI:EDGE_LO]);
      sel_nxt  = pwdata[SEL_HI:0];
    end
    if (flag_set) begin
      flag_nxt = 1'b1; // set beats a clear in the same cycle
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_r  <= '0;
      flag_r <= 1'b0;
      mode_r <= EDGE_OFF;
      sel_r  <= SEL_RST;
    end else begin
      mod_r  <= mod_nxt;
      flag_r <= flag_nxt;
      mode_r <= mode_nxt;
      sel_r  <= sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable; other_reset wipes this part only
  assign mod_rise = |(module_flag_in & ~mod_r);
  always_comb begin
    events               = '0;
    events[IRQ_FILT_BIT] = flag_set;
    events[IRQ_MOD_BIT]  = mod_rise;
    stat_nxt = stat_r;
    en_nxt   = en_r;
    if (wr_b0 && paddr == ADDR_IRQ_CLR) begin
      stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
    end
    if (wr_b0 && paddr == ADDR_IRQ_EN) begin
      en_nxt = pwdata[IRQ_W-1:0];
    end
    if (other_reset) begin
      stat_nxt = '0;
      en_nxt   = IRQ_EN_RST;
    end
    stat_nxt = stat_nxt | events; // new events survive a clear
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      en_r   <= IRQ_EN_RST;
    end else begin
      stat_r <= stat_nxt;
      en_r   <= en_nxt;
    end
  end

  assign irq = |(stat_r & en_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  mod_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == ADDR_MODFLAGS
    |=> prdata[MODS-1:0] == $past(mod_r) && prdata[DATA_W-1:MODS] == '0)
    else $error("module flag read mismatch");
  mod_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 mod_r == $past(module_flag_in))
    else $error("module flags do not mirror peripherals");
  mod_nowr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b0 && paddr == ADDR_MODFLAGS |=> mod_r == $past(module_flag_in))
    else $error("write changed module flags");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    detect && lls_active |=> flag_r && stat_r[IRQ_FILT_BIT])
    else $error("filter wake not recorded");
  flag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b0 && paddr == ADDR_FILT1 && !flag_set
    |=> flag_r == ($past(flag_r) && !$past(pwdata[FLAG_BIT])))
    else $error("detect flag write-one-clear wrong");
  mode_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b0 && paddr == ADDR_FILT1 |=> mode_r == $past(pwdata[EDGE_HI:EDGE_LO]))
    else $error("edge mode not stored");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == ADDR_FILT1 |=> !prdata[RSVD_BIT])
    else $error("reserved bit read one");
  keep_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    other_reset && !wr_acc
    |=> mode_r == $past(mode_r) && sel_r == $past(sel_r) && en_r == IRQ_EN_RST)
    else $error("other reset touched filter register");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    stat_r[IRQ_FILT_BIT] && en_r[IRQ_FILT_BIT] |-> irq)
    else $error("enabled status without interrupt");
  flag_set_c: cover property (@(posedge pclk) disable iff (!presetn) flag_set);
  flag_clr_c: cover property (@(posedge pclk) disable iff (!presetn)
    flag_r ##1 !flag_r);
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  err_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// [testbench/wake_source_model.sv]
// far-side model: peripheral wakeup flags and external wakeup pins
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  input  wire logic        pclk,
  input  wire logic [7:0]  flag_set,
  input  wire logic [7:0]  flag_clr,
  input  wire logic [15:0] pin_lvl,
  output var logic  [7:0]  module_flag_in,
  output var logic  [15:0] wake_pins
);
  // known levels from time zero
  initial begin
    module_flag_in = 8'h00;
    wake_pins      = 16'h0000;
  end
  // peripheral flags are sticky and only the peripheral clears them
  always @(posedge pclk) begin
    module_flag_in <= (module_flag_in | flag_set) & ~flag_clr;
    wake_pins      <= pin_lvl;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the wakeup flag and pin filter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wakeup_pkg::*;
  localparam int DIV    = 4;
  localparam int SETTLE = DIV * 12;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, flag_set = 8'h00, flag_clr = 8'h00, module_flag_in;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [3:0]  pstrb = 4'hF;
  logic [15:0] pin_lvl = 16'h0000, wake_pins;
  logic        pready, pslverr, irq, err_v, lls_active = 1'b1, other_reset = 1'b0;
  int          failures = 0, n_compared = 0, cyc = 0;

  wakeup_flags_pin_filter #(.LPO_DIV(DIV)) u_wakeup_flags_pin_filter (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_flag_in(module_flag_in), .wake_pins(wake_pins),
    .lls_active(lls_active), .other_reset(other_reset), .irq(irq));
  wake_source_model u_wake_source_model (
    .pclk(pclk), .flag_set(flag_set), .flag_clr(flag_clr), .pin_lvl(pin_lvl),
    .module_flag_in(module_flag_in), .wake_pins(wake_pins));

  // 100 MHz clock and a hang guard well above the expected run
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait; it has no limit of its own, so a stuck pready is ended only by the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd_v);
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk("irq", 32'(exp), 32'(irq));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    rd_chk("filt rst", ADDR_FILT1, 32'h0);
    rd_chk("modflags rst", ADDR_MODFLAGS, 32'h0);
    apb(1'b1, ADDR_FILT1, 32'hFF);
    rd_chk("filt fields", ADDR_FILT1, 32'h6F);
    apb(1'b1, ADDR_FILT1, 32'h0);
    // byte lane zero off: the write must be dropped
    pstrb <= 4'hE;
    apb(1'b1, ADDR_FILT1, 32'h2A);
    pstrb <= 4'hF;
    rd_chk("strobe off", ADDR_FILT1, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, 32'(err_v));
    chk("unmapped data", 32'h0, rd_v);
    $display("test regs done");
  endtask
  task automatic test_modflags();
    @(posedge pclk) flag_set <= 8'hA5;
    @(posedge pclk) flag_set <= 8'h00;
    repeat (3) @(posedge pclk);
    rd_chk("modflags", ADDR_MODFLAGS, 32'hA5);
    irq_chk(1'b0);
    rd_chk("irq stat", ADDR_IRQ_STAT, 32'h2);
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    irq_chk(1'b1);
    apb(1'b1, ADDR_MODFLAGS, 32'hFF);
    rd_chk("modflags w1", ADDR_MODFLAGS, 32'hA5);
    apb(1'b1, ADDR_IRQ_CLR, 32'h2);
    irq_chk(1'b0);
    @(posedge pclk) flag_clr <= 8'hA5;
    @(posedge pclk) flag_clr <= 8'h00;
    repeat (3) @(posedge pclk);
    rd_chk("modflags clr", ADDR_MODFLAGS, 32'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    $display("test modflags done");
  endtask
  // configure, let the filter settle, clear stale flags, then move the pin
  task automatic filter_case(input logic [1:0] mode, input int sel, input int pin,
                             input logic st, input logic fin, input logic exp);
    logic [31:0] cfg;
    cfg = (32'(mode) << 5) | 32'(sel);
    @(posedge pclk);
    pin_lvl <= 16'(st) << pin;
    apb(1'b1, ADDR_FILT1, cfg);
    repeat (SETTLE) @(posedge pclk);
    apb(1'b1, ADDR_FILT1, cfg | 32'h80);
    apb(1'b1, ADDR_IRQ_CLR, 32'h1);
    pin_lvl <= 16'(fin) << pin;
    repeat (SETTLE) @(posedge pclk);
    rd_chk("detect", ADDR_FILT1, exp ? (cfg | 32'h80) : cfg);
    irq_chk(exp);
    if (exp) begin
      apb(1'b1, ADDR_FILT1, cfg);
      rd_chk("flag kept", ADDR_FILT1, cfg | 32'h80);
      apb(1'b1, ADDR_FILT1, cfg | 32'h80);
      rd_chk("flag clr", ADDR_FILT1, cfg);
    end
  endtask
  task automatic test_filter();
    filter_case(2'b00, 1, 1, 1'b0, 1'b1, 1'b0);
    filter_case(2'b01, 15, 15, 1'b0, 1'b1, 1'b1);
    filter_case(2'b10, 3, 3, 1'b1, 1'b0, 1'b1);
    filter_case(2'b11, 7, 7, 1'b1, 1'b0, 1'b1);
    filter_case(2'b01, 5, 5, 1'b1, 1'b0, 1'b0);
    filter_case(2'b01, 0, 1, 1'b0, 1'b1, 1'b0);
    filter_case(2'b11, 0, 0, 1'b0, 1'b1, 1'b1);
    // awake: a filtered edge outside low-leakage stop must not set the flag
    @(posedge pclk) lls_active <= 1'b0;
    filter_case(2'b01, 2, 2, 1'b0, 1'b1, 1'b0);
    @(posedge pclk) lls_active <= 1'b1;
    $display("test filter done");
  endtask
  task automatic test_resets();
    apb(1'b1, ADDR_FILT1, 32'h4A);
    apb(1'b1, ADDR_IRQ_EN, 32'h3);
    @(posedge pclk) other_reset <= 1'b1;
    @(posedge pclk) other_reset <= 1'b0;
    rd_chk("filt kept", ADDR_FILT1, 32'h4A);
    rd_chk("en cleared", ADDR_IRQ_EN, 32'h0);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("filt chip rst", ADDR_FILT1, 32'h0);
    $display("test resets done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_modflags();
    test_filter();
    test_resets();
    summarize();
  end
endmodule
`default_nettype wire
